// ### sio8_pkg.sv
package sio8_pkg;

  // Register indices on the plain register port.
  localparam logic [1:0] CTRL_OFS = 2'h0;
  localparam logic [1:0] STAT_OFS = 2'h1;
  localparam logic [1:0] DATA_OFS = 2'h2;

  // Control register fields; the clock select sits in bits 2 to 0.
  localparam int CLK_SEL_LSB = 0;
  localparam int MODE_LSB    = 4;
  localparam int ABORT_BIT   = 6;
  localparam int RUN_BIT     = 7;

  // Status register fields.
  localparam int SHIFTING_BIT = 0;
  localparam int UNREAD_BIT   = 1;
  localparam int WRITTEN_BIT  = 2;
  localparam int ACTIVE_BIT   = 3;

  // Values after reset.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Clock select code that takes the shift clock from the pin.
  localparam logic [2:0] CLK_EXT = 3'h7;

  // Transfer modes held in the two-bit mode field.
  typedef enum logic [1:0] {
    MODE_TX   = 2'h0,
    MODE_RX   = 2'h1,
    MODE_TXRX = 2'h2,
    MODE_RSVD = 2'h3
  } xfer_mode_t;

  // Shifter sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SHIFT = 4'h2,
    ST_WAIT  = 4'h4,
    ST_END   = 4'h8
  } sio_state_t;

  // Timing: one machine cycle is taken as one system clock period.
  localparam int CLK_PERIOD_NS     = 25;
  localparam int MACH_CYCLE_NS     = 25;
  localparam int EXT_MIN_PULSE_NS  = 4 * MACH_CYCLE_NS;
  localparam int EXT_MIN_PULSE_CYC =
    (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LAST_BIT = 3'h7;

endpackage

// ### pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // Two stages; the first one is read by the second stage only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ### sck_divider.sv
`timescale 1ns/10ps
module sck_divider
  import sio8_pkg::*;
#(
  parameter int BASE = EXT_MIN_PULSE_CYC
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Rate select and restart while the shifter is parked.
  input  wire logic [2:0] sel,
  input  wire logic       restart,
  // One-cycle pulse at each half period of the serial clock.
  output logic            tick
);

  logic [15:0] cnt_q;
  logic [15:0] limit;

  // Half period doubles with each step of the select code.
  assign limit = 16'(BASE << sel) - 16'h0001;

  // Restarting keeps the first half period full length after a wait.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (restart || cnt_q >= limit) begin
      cnt_q <= 16'h0000;
      tick  <= !restart;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule

// ### sio8_shift.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module sio8_shift
  import sio8_pkg::*;
#(
  parameter int DIV_BASE = EXT_MIN_PULSE_CYC
) (
  // System clock and reset.
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  // Register port.
  input  wire logic [1:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Shift clock pin.
  input  wire logic       SHIFT_CLK_I,
  output logic            SHIFT_CLK_O,
  output logic            SHIFT_CLK_OE_N,
  // Serial data pins.
  input  wire logic       SERIAL_IN,
  output logic            SERIAL_OUT,
  // Buffer event.
  output logic            BUFFER_IRQ
);

  // Direction decode of the mode field.
  function automatic logic tx_dir(input xfer_mode_t m);
    return (m == MODE_TX) || (m == MODE_TXRX);
  endfunction

  function automatic logic rx_dir(input xfer_mode_t m);
    return (m == MODE_RX) || (m == MODE_TXRX);
  endfunction

  sio_state_t state_q;
  xfer_mode_t mode_q;
  logic [2:0] clk_sel_q, cnt_q;
  logic [7:0] sh_q, buf_q, sh_next;
  logic       run_q, abort_q, unread_q, written_q, active_q, dummy_q;
  logic       sck_prev_q, sck_s, si_s, tick;
  logic       tx_en, rx_en, ext, shifting, lead_ev, trail_ev;
  logic       word_done, overflow, ready, start, load_ev, end_ev;
  logic       ctrl_wr, mode_chg, data_rd, data_wr;

  // Both pin inputs go through the same two stages, so data and clock
  // keep their relative timing at the sampling point.
  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RSTN),
    .d     ({SHIFT_CLK_I, SERIAL_IN}),
    .q     ({sck_s, si_s})
  );

  // Internal rate generator, parked while no word is shifting.
  sck_divider #(
    .BASE (DIV_BASE)
  ) u_div (
    .clk     (MCLK),
    .rst_n   (RSTN),
    .sel     (clk_sel_q),
    .restart (!shifting || ext),
    .tick    (tick)
  );

  // Register port decode.
  assign ctrl_wr  = WR && (ADDR == CTRL_OFS);
  assign mode_chg = ctrl_wr && (WDATA[MODE_LSB+:2] != mode_q);
  assign data_rd  = RD && (ADDR == DATA_OFS);
  assign data_wr  = WR && (ADDR == DATA_OFS);

  // Mode and clock source decode.
  assign tx_en = tx_dir(mode_q);
  assign rx_en = rx_dir(mode_q);
  assign ext   = (clk_sel_q == CLK_EXT);

  // Leading edge is the falling pin edge, trailing edge the rising one;
  // an internal clock makes them from divider ticks.
  assign shifting = (state_q == ST_SHIFT);
  assign lead_ev  = shifting && (ext ? (sck_prev_q && !sck_s)
                                     : (tick && SHIFT_CLK_O));
  assign trail_ev = shifting && (ext ? (!sck_prev_q && sck_s)
                                     : (tick && !SHIFT_CLK_O));
  assign word_done = trail_ev && (cnt_q == LAST_BIT);
  assign sh_next   = {si_s, sh_q[7:1]};

  // An external peer that completes a word over an unread one overruns.
  assign overflow = ext && rx_en && unread_q;

  // Next word may go once read and written as the mode needs.
  assign ready = (!tx_en || written_q) && (!rx_en || !unread_q);

  // Sequencer events.
  assign start   = (state_q == ST_IDLE) && run_q && !abort_q &&
                   (mode_q != MODE_RSVD) && (!tx_en || written_q);
  assign end_ev  = (state_q == ST_END);
  assign load_ev = !abort_q && (start ||
                   ((state_q == ST_WAIT) && run_q && ready) ||
                   (word_done && run_q && !dummy_q && !overflow &&
                    (ext ? written_q || !tx_en : ready && !rx_en)));

  // Control register; hardware drops run at the end of an operation,
  // but a software write in the same cycle wins.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_sel_q <= CTRL_RST[CLK_SEL_LSB+:3];
      mode_q    <= xfer_mode_t'(CTRL_RST[MODE_LSB+:2]);
      run_q     <= CTRL_RST[RUN_BIT];
      abort_q   <= CTRL_RST[ABORT_BIT];
    end else if (ctrl_wr) begin
      clk_sel_q <= WDATA[CLK_SEL_LSB+:3];
      mode_q    <= xfer_mode_t'(WDATA[MODE_LSB+:2]);
      run_q     <= WDATA[RUN_BIT];
      abort_q   <= WDATA[ABORT_BIT];
    end else begin
      abort_q <= 1'b0; // Abort clears itself after acting.
      if (end_ev || abort_q) begin
        run_q <= 1'b0;
      end
    end
  end

  // Sequencer.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      dummy_q <= 1'b0;
    end else if (abort_q) begin
      state_q <= ST_IDLE;
      dummy_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          dummy_q <= 1'b0;
          if (start) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (word_done) begin
            if (!run_q || dummy_q || overflow) begin
              state_q <= ST_END;
            end else if (ext && tx_en && !written_q) begin
              dummy_q <= 1'b1;
            end else if (!ext && !load_ev) begin
              state_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (!run_q) begin
            state_q <= ST_END;
          end else if (ready) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_END: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Transfer-active flag follows the operation from start to its end.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      active_q <= 1'b0;
    end else if (abort_q || end_ev) begin
      active_q <= 1'b0;
    end else if (start) begin
      active_q <= 1'b1;
    end
  end

  // Shift register and bit counter; a load in the last trailing cycle
  // takes priority so the next word follows without a gap.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sh_q  <= DATA_RST;
      cnt_q <= 3'h0;
    end else if (load_ev) begin
      if (tx_en) begin
        sh_q <= buf_q;
      end
      cnt_q <= 3'h0;
    end else if (trail_ev) begin
      sh_q  <= sh_next;
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Shared data buffer; a mode change wipes it, a finished received
  // word overwrites it, and software writes otherwise.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      buf_q <= DATA_RST;
    end else if (mode_chg) begin
      buf_q <= DATA_RST;
    end else if (word_done && rx_en && !overflow) begin
      buf_q <= sh_next;
    end else if (data_wr) begin
      buf_q <= WDATA;
    end
  end

  // Unread flag: a new word sets it, and the set wins over a read.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      unread_q <= 1'b0;
    end else if (mode_chg) begin
      unread_q <= 1'b0;
    end else if (word_done && rx_en && !overflow) begin
      unread_q <= 1'b1;
    end else if (data_rd) begin
      unread_q <= 1'b0;
    end
  end

  // Written flag: a software write sets it and wins over the load.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      written_q <= 1'b0;
    end else if (mode_chg) begin
      written_q <= 1'b0;
    end else if (data_wr) begin
      written_q <= 1'b1;
    end else if (load_ev && tx_en) begin
      written_q <= 1'b0;
    end
  end

  // Buffer event: empty on a transmit-only load, full on a kept word.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      BUFFER_IRQ <= 1'b0;
    end else begin
      BUFFER_IRQ <= (load_ev && mode_q == MODE_TX) ||
                    (word_done && rx_en && !overflow && !abort_q);
    end
  end

  // Serial output changes only on a leading edge, so the last bit
  // stands until the next falling edge.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      SERIAL_OUT <= 1'b1;
    end else if (lead_ev && tx_en) begin
      SERIAL_OUT <= sh_q[0];
    end
  end

  // Internal shift clock idles high and stops whenever the sequencer
  // leaves the shift state; that is the automatic wait.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      SHIFT_CLK_O <= 1'b1;
    end else if (!shifting || ext) begin
      SHIFT_CLK_O <= 1'b1;
    end else if (tick) begin
      SHIFT_CLK_O <= !SHIFT_CLK_O;
    end
  end

  // Pin is released whenever the clock comes from the peer.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      SHIFT_CLK_OE_N <= 1'b1;
      sck_prev_q     <= 1'b1;
    end else begin
      SHIFT_CLK_OE_N <= ext;
      sck_prev_q     <= sck_s;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        CTRL_OFS: RDATA <= {run_q, 1'b0, mode_q, 1'b0, clk_sel_q};
        STAT_OFS: RDATA <= {4'h0, active_q, written_q, unread_q,
                            shifting};
        DATA_OFS: RDATA <= buf_q;
        default:  RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Checks.
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  sequence s_word_kept;
    word_done && rx_en && !overflow && !abort_q;
  endsequence

  sequence s_start;
    start;
  endsequence

  property p_sample_rise;
    trail_ev && !load_ev |=> sh_q[7] == $past(si_s);
  endproperty
  a_sample_rise: assert property (p_sample_rise)
    else $error("Input bit not taken on trailing edge.");

  property p_lead_out;
    lead_ev && tx_en |=> SERIAL_OUT == $past(sh_q[0]);
  endproperty
  a_lead_out: assert property (p_lead_out)
    else $error("Output bit not driven on leading edge.");

  property p_out_hold;
    active_q && !lead_ev |=> $stable(SERIAL_OUT);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("Serial output moved away from a leading edge.");

  property p_start_active;
    s_start ##0 !abort_q |=> active_q && shifting;
  endproperty
  a_start_active: assert property (p_start_active)
    else $error("Start did not raise active flag.");

  property p_abort;
    abort_q |=> !active_q && state_q == ST_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("Abort did not stop the transfer at once.");

  property p_tx_empty;
    load_ev && mode_q == MODE_TX && !data_wr |=> BUFFER_IRQ && !written_q;
  endproperty
  a_tx_empty: assert property (p_tx_empty)
    else $error("Load did not empty buffer and signal.");

  property p_rx_full;
    s_word_kept |=> BUFFER_IRQ && unread_q && buf_q == $past(sh_next);
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("Received word not copied with event.");

  property p_wait_clock;
    state_q == ST_WAIT && !ext |=> SHIFT_CLK_O [*2];
  endproperty
  a_wait_clock: assert property (p_wait_clock)
    else $error("Serial clock ran during a wait.");

  property p_overrun;
    word_done && overflow && !abort_q |=> state_q == ST_END ##1 !active_q;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("Overrun did not end the reception.");

  property p_stop_end;
    word_done && !run_q && !abort_q |=> ##1 !active_q && !shifting;
  endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("Run clear did not end after the word.");

endmodule

// ### serial_peer.sv
`timescale 1ns/10ps
module serial_peer (
  // Shared clock wire and the two data lines.
  input  wire logic       sck_wire,
  input  wire logic       so,
  output logic            sck_drv,
  output logic            si,
  // Last eight bits taken from the device and a running bit count.
  output logic      [7:0] got,
  output int              bits
);
  logic [7:0] tx;
  int         fidx;
  int         ridx;

  // The clock line rests high between frames.
  initial begin
    sck_drv = 1'b1;
    si = 1'b1;
    got = 8'h00;
    bits = 0;
    tx = 8'h00;
    fidx = 0;
    ridx = 0;
  end

  // Queue a word; its first bit must stand before the first rising edge.
  task automatic send_byte(input logic [7:0] b);
    tx = b;
    fidx = 0;
    ridx = 0;
    si = b[0];
  endtask

  // Eight periods of 200 ns with 100 ns in each phase, then park high.
  task automatic clock_word();
    repeat (8) begin
      sck_drv = 1'b0;
      #100;
      sck_drv = 1'b1;
      #100;
    end
  endtask

  // The next bit goes out on each falling edge after the first one.
  always @(negedge sck_wire) begin
    if (fidx > 0 && fidx < 8)
      si = tx[fidx];
    fidx = fidx + 1;
  end

  // Device output is taken once settled; after the word the line flips,
  // so a stale bit can never be mistaken for a held one.
  always @(posedge sck_wire) begin
    #70;
    got = {so, got[7:1]};
    bits = bits + 1;
    ridx = ridx + 1;
    if (ridx == 8)
      si = ~si;
  end
endmodule

// ### sio8_shift_bench.sv
`timescale 1ns/10ps
module sio8_shift_bench
  import sio8_pkg::*;
;
  // Design pins and bench bookkeeping.
  logic       MCLK, RSTN, WR, RD, SERIAL_IN, SERIAL_OUT, BUFFER_IRQ;
  logic       SHIFT_CLK_O, SHIFT_CLK_OE_N, peer_sck;
  wire logic  sck_wire;
  logic [1:0] ADDR;
  logic [7:0] WDATA, RDATA, d, got;
  int         fail_count, checked, irq_n, cyc, n0, i0, bits;

  typedef struct {
    xfer_mode_t mode;
    logic [7:0] txb, rxb;
    logic       sends, takes;
  } row_t;
  row_t       rows [3];

  // The pin carries the device clock only while the device drives it.
  assign sck_wire = SHIFT_CLK_OE_N ? peer_sck : SHIFT_CLK_O;

  sio8_shift #(.DIV_BASE(4)) uut (
    .MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SHIFT_CLK_I(sck_wire),
    .SHIFT_CLK_O(SHIFT_CLK_O), .SHIFT_CLK_OE_N(SHIFT_CLK_OE_N),
    .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
    .BUFFER_IRQ(BUFFER_IRQ)
  );

  serial_peer peer (
    .sck_wire(sck_wire), .so(SERIAL_OUT), .sck_drv(peer_sck),
    .si(SERIAL_IN), .got(got), .bits(bits)
  );

  // Compare and count; a mismatch is reported at once.
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask

  // Each strobe is lowered, then one edge passes before the next request.
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(posedge MCLK);
    v = RDATA;
  endtask

  task automatic wait_bits(input int n);
    for (int k = 0; k < 4000 && bits < n; k++)
      @(posedge MCLK);
    chk("bit count", 8'(n), 8'(bits));
  endtask

  task automatic wait_idle();
    logic [7:0] v;
    v = 8'hFF;
    for (int k = 0; k < 200 && v[ACTIVE_BIT] !== 1'b0; k++)
      reg_rd(STAT_OFS, v);
    chk("active end", 8'h00, v & 8'h08);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  // Events are counted off the sampling edge to stay clear of races.
  always @(negedge MCLK) begin
    if (BUFFER_IRQ === 1'b1)
      irq_n++;
  end

  // A hang ends the run through the same closing report.
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      $display("wrong value run length expected 10000 seen more");
      conclude();
    end
  end

  initial begin
    RSTN = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 2'h0;
    WDATA = 8'h00;
    rows[0] = '{MODE_TX, 8'hA5, 8'h00, 1'b1, 1'b0};
    rows[1] = '{MODE_RX, 8'h00, 8'h3C, 1'b0, 1'b1};
    rows[2] = '{MODE_TXRX, 8'hC3, 8'h96, 1'b1, 1'b1};
    repeat (5) @(posedge MCLK);
    chk("reset pins", 8'h03, {6'h0, SHIFT_CLK_OE_N, SERIAL_OUT});
    chk("reset data", 8'h00, RDATA);
    repeat (5) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (2) @(posedge MCLK);
    chk("idle pins", 8'h03, {SHIFT_CLK_OE_N, 5'h0, SHIFT_CLK_O, SERIAL_OUT});
    reg_rd(CTRL_OFS, d);
    chk("ctrl", CTRL_RST, d);
    reg_rd(STAT_OFS, d);
    chk("status", 8'h00, d);
    reg_rd(2'h3, d);
    chk("unmapped", 8'h00, d);
    $display("test reset ended");
    // One word in each mode on the internal clock.
    foreach (rows[i]) begin
      reg_wr(CTRL_OFS, {2'b00, rows[i].mode, 4'h0});
      peer.send_byte(rows[i].rxb);
      if (rows[i].sends)
        reg_wr(DATA_OFS, rows[i].txb);
      n0 = bits;
      i0 = irq_n;
      reg_wr(CTRL_OFS, {2'b10, rows[i].mode, 4'h0});
      reg_rd(STAT_OFS, d);
      chk("active", 8'h08, d & 8'h08);
      wait_bits(n0 + 8);
      repeat (20) @(posedge MCLK);
      chk("irq count", 8'h01, 8'(irq_n - i0));
      reg_wr(CTRL_OFS, {2'b00, rows[i].mode, 4'h0});
      wait_idle();
      if (rows[i].sends) begin
        chk("sent", rows[i].txb, got);
        chk("held", {7'h0, rows[i].txb[7]}, {7'h0, SERIAL_OUT});
      end
      if (rows[i].takes) begin
        reg_rd(DATA_OFS, d);
        chk("taken", rows[i].rxb, d);
      end
      $display("test row %0d ended", i);
    end
    // Two queued words, a pause with the clock parked high, then resume.
    reg_wr(CTRL_OFS, 8'h00);
    reg_wr(DATA_OFS, 8'h5A);
    n0 = bits;
    i0 = irq_n;
    reg_wr(CTRL_OFS, 8'h80);
    repeat (4) @(posedge MCLK);
    reg_wr(DATA_OFS, 8'h81);
    wait_bits(n0 + 16);
    repeat (60) @(posedge MCLK);
    chk("paused bits", 8'h10, 8'(bits - n0));
    chk("paused clock", 8'h01, {7'h0, SHIFT_CLK_O});
    chk("second word", 8'h81, got);
    chk("loads", 8'h02, 8'(irq_n - i0));
    reg_wr(DATA_OFS, 8'h7E);
    wait_bits(n0 + 24);
    chk("resumed word", 8'h7E, got);
    reg_wr(CTRL_OFS, 8'h00);
    wait_idle();
    $display("test wait ended");
    // Run cleared in mid-word: the word completes, then active drops.
    reg_wr(DATA_OFS, 8'h3C);
    n0 = bits;
    reg_wr(CTRL_OFS, 8'h80);
    wait_bits(n0 + 2);
    reg_wr(CTRL_OFS, 8'h00);
    wait_idle();
    chk("stop bits", 8'h08, 8'(bits - n0));
    chk("stop word", 8'h3C, got);
    $display("test stop ended");
    // Abort in mid-word.
    reg_wr(DATA_OFS, 8'hFF);
    n0 = bits;
    reg_wr(CTRL_OFS, 8'h80);
    wait_bits(n0 + 3);
    reg_wr(CTRL_OFS, 8'h40);
    repeat (2) @(posedge MCLK);
    reg_rd(STAT_OFS, d);
    chk("abort active", 8'h00, d & 8'h08);
    n0 = bits;
    repeat (60) @(posedge MCLK);
    chk("abort bits", 8'h00, 8'(bits - n0));
    $display("test abort ended");
    // The reserved mode code never starts.
    reg_wr(CTRL_OFS, 8'h30);
    reg_wr(CTRL_OFS, 8'hB0);
    repeat (4) @(posedge MCLK);
    reg_rd(STAT_OFS, d);
    chk("reserved", 8'h00, d & 8'h08);
    $display("test reserved ended");
    // External clock receive; the second word overruns an unread one.
    reg_wr(CTRL_OFS, 8'h17);
    @(posedge MCLK);
    chk("pin drive", 8'h01, {7'h0, SHIFT_CLK_OE_N});
    i0 = irq_n;
    reg_wr(CTRL_OFS, 8'h97);
    #7;
    peer.send_byte(8'h6D);
    peer.clock_word();
    repeat (10) @(posedge MCLK);
    peer.send_byte(8'h92);
    peer.clock_word();
    repeat (10) @(posedge MCLK);
    chk("ext irqs", 8'h01, 8'(irq_n - i0));
    reg_rd(STAT_OFS, d);
    chk("overrun end", 8'h00, d & 8'h08);
    reg_rd(DATA_OFS, d);
    chk("ext word", 8'h6D, d);
    $display("test external ended");
    // External transmit: a byte written during the first word goes out
    // next; with no byte and run left set, one dummy word ends the run.
    reg_wr(CTRL_OFS, 8'h07);
    reg_wr(DATA_OFS, 8'h4B);
    i0 = irq_n;
    reg_wr(CTRL_OFS, 8'h87);
    reg_wr(DATA_OFS, 8'hD2);
    #7;
    peer.clock_word();
    chk("ext first", 8'h4B, got);
    peer.clock_word();
    chk("ext second", 8'hD2, got);
    peer.clock_word();
    repeat (10) @(posedge MCLK);
    chk("ext loads", 8'h02, 8'(irq_n - i0));
    reg_rd(STAT_OFS, d);
    chk("dummy end", 8'h00, d & 8'h08);
    $display("test external transmit ended");
    conclude();
  end
endmodule
